// ===== include/ampo_pkg.sv
// Shared constants and types for the axis mode 3 pulse output block
package ampo_pkg;
   localparam int          NUM_AXES   = 4;
   localparam int          MODE_W     = 16;
   // Byte addresses of the bus registers
   localparam logic [3:0]  ADDR_AXIS  = 4'h0;
   localparam logic [3:0]  ADDR_MODE3 = 4'h4;
   localparam logic [3:0]  ADDR_STAT  = 4'h8;
   localparam logic [15:0] MODE3_RST  = 16'h0000;
   localparam logic [1:0]  AXIS_RST   = 2'h0;
   // Field positions in axis_mode_register_three
   localparam int          BIT_MANUAL_DECEL = 0;
   localparam int          BIT_ASYM         = 1;
   localparam int          BIT_SCURVE       = 2;
   localparam int          BIT_FMT_LO       = 3;
   localparam int          BIT_FMT_HI       = 4;
   localparam int          BIT_PULSE_POL    = 5;
   localparam int          BIT_DIR_POL      = 6;
   localparam int          BIT_SWAP         = 7;
   // Pulse output formats
   localparam logic [1:0]  FMT_TWO_PULSE = 2'h0;
   localparam logic [1:0]  FMT_STEP_DIR  = 2'h1;
   localparam logic [1:0]  FMT_QUAD4     = 2'h2;
   localparam logic [1:0]  FMT_QUAD2     = 2'h3;
   // Pulse timing in clock cycles
   localparam logic [3:0]  PULSE_HIGH_CYC = 4'h2;
   localparam logic [3:0]  PULSE_LOW_CYC  = 4'h2;
   typedef enum logic [2:0] {
      PS_IDLE = 3'b001,
      PS_HIGH = 3'b010,
      PS_LOW  = 3'b100
   } ampo_pulse_state_type;
endpackage : ampo_pkg

// ===== logic/ampo_wb_slave.sv
// Classic Wishbone slave handshake with registered read data
`timescale 1ns/1ns
module ampo_wb_slave
   import ampo_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] rdata_i,
   output logic             wb_ack_o,
   output logic [31:0]      wb_dat_o,
   output logic             wr_en_o
);
   logic        ack_reg;
   logic        ack_next;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;

   // Write lands on the edge where the master sees ack
   assign wr_en_o  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   always_comb begin
      ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
      dat_next = 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg) begin
         dat_next = rdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end
endmodule : ampo_wb_slave

// ===== logic/ampo_axis_pulse.sv
// One axis: step pulse timing and quadrature phase sequencer
`timescale 1ns/1ns
module ampo_axis_pulse
   import ampo_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic step_i,
   input  wire logic neg_i,
   input  wire logic double_i,
   output logic      pulse_o,
   output logic      phase_a_o,
   output logic      phase_b_o,
   output logic      busy_o
);
   ampo_pulse_state_type state_reg;
   ampo_pulse_state_type state_next;
   logic [3:0]           cnt_reg;
   logic [3:0]           cnt_next;
   logic [1:0]           quad_reg;
   logic [1:0]           quad_next;
   logic                 pulse_reg;
   logic                 pulse_next;
   logic                 neg_reg;
   logic                 neg_next;

   // A leads B for positive motion
   assign phase_a_o = quad_reg[1] ^ quad_reg[0];
   assign phase_b_o = quad_reg[1];
   assign pulse_o   = pulse_reg;
   assign busy_o    = (state_reg != PS_IDLE);

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      quad_next  = quad_reg;
      pulse_next = pulse_reg;
      neg_next   = neg_reg;
      case (state_reg)
         PS_IDLE: begin
            // Steps during a pulse are dropped; generator must pace them
            if (step_i) begin
               pulse_next = 1'b1;
               neg_next   = neg_i;
               quad_next  = neg_i ? quad_reg - 2'h1 : quad_reg + 2'h1;
               cnt_next   = PULSE_HIGH_CYC - 4'h1;
               state_next = PS_HIGH;
            end
         end
         PS_HIGH: begin
            cnt_next = cnt_reg - 4'h1;
            if (cnt_reg == 4'h0) begin
               pulse_next = 1'b0;
               // Double edge: second quarter of the step halfway through
               if (double_i) begin
                  quad_next = neg_reg ? quad_reg - 2'h1 : quad_reg + 2'h1;
               end
               cnt_next   = PULSE_LOW_CYC - 4'h1;
               state_next = PS_LOW;
            end
         end
         PS_LOW: begin
            cnt_next = cnt_reg - 4'h1;
            if (cnt_reg == 4'h0) begin
               state_next = PS_IDLE;
            end
         end
         default: begin
            state_next = PS_IDLE;
            pulse_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= PS_IDLE;
         cnt_reg   <= 4'h0;
         quad_reg  <= 2'h0;
         pulse_reg <= 1'b0;
         neg_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         quad_reg  <= quad_next;
         pulse_reg <= pulse_next;
         neg_reg   <= neg_next;
      end
   end
endmodule : ampo_axis_pulse

// ===== logic/ampo_axis_mode3.sv
// Per-axis mode register 3 with drive pulse output formatter
// Notes on behaviour
// - Each axis has its own mode register, written through the axis last selected.
// - Bit 0 picks automatic (0) or manual (1) deceleration; manual needs a decel_point.
// - Bit 1 at 0 reuses acceleration rate and jerk for decel, at 1 uses separate ones.
// - Bit 2 picks linear (0) or S-curve (1); jerk_rate must be loaded first.
// - Bits 4:3 pick two-pulse, pulse and direction, quadrature x4 or quadrature x2.
// - Two-pulse format puts plus steps on output 1 and minus steps on output 2.
// - Pulse and direction format puts all steps on output 1 and direction on output 2.
// - Quadrature format puts phase A on output 1 and phase B on output 2.
// - Bit 5 makes drive pulses active high at 0 and active low at 1.
// - Bit 6 at 0 drives direction low for plus and high for minus, at 1 the reverse.
// - Bit 7 swaps the two output pins in every format.
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module ampo_axis_mode3
   import ampo_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic [3:0]          wb_adr_i,
   input  wire logic [31:0]         wb_dat_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic                wb_we_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   input  wire logic [NUM_AXES-1:0] move_active_i,
   input  wire logic [NUM_AXES-1:0] move_dir_i,
   input  wire logic [NUM_AXES-1:0] step_i,
   output logic [NUM_AXES-1:0]      drive_out1_o,
   output logic [NUM_AXES-1:0]      drive_out2_o,
   output logic [NUM_AXES-1:0]      manual_decel_select_o,
   output logic [NUM_AXES-1:0]      asymmetric_profile_select_o,
   output logic [NUM_AXES-1:0]      scurve_select_o
);
   logic        wr_en;
   logic [31:0] rdata;
   logic [1:0]  axis_reg;
   logic [1:0]  axis_next;
   logic [15:0] mode_reg   [NUM_AXES];
   logic [15:0] mode_next  [NUM_AXES];
   logic        dir_reg    [NUM_AXES];
   logic        dir_next   [NUM_AXES];
   logic        act_reg    [NUM_AXES];
   logic        out1_reg   [NUM_AXES];
   logic        out1_next  [NUM_AXES];
   logic        out2_reg   [NUM_AXES];
   logic        out2_next  [NUM_AXES];
   logic        dir_use    [NUM_AXES];
   logic        pulse_raw  [NUM_AXES];
   logic        phase_a    [NUM_AXES];
   logic        phase_b    [NUM_AXES];
   logic        busy       [NUM_AXES];
   logic [NUM_AXES-1:0] busy_v;
   logic [NUM_AXES-1:0] dir_v;
   logic [NUM_AXES-1:0] fault_v;
   logic        mode_sel;
   logic        axis_sel;

   assign mode_sel = (wb_adr_i[3:2] == ADDR_MODE3[3:2]);
   assign axis_sel = (wb_adr_i[3:2] == ADDR_AXIS[3:2]);

   ampo_wb_slave u_wb (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .rdata_i  (rdata),
      .wb_ack_o (wb_ack_o),
      .wb_dat_o (wb_dat_o),
      .wr_en_o  (wr_en)
   );

   // Stands in for the axis field of the last command or no-op
   always_comb begin
      axis_next = axis_reg;
      if (wr_en && axis_sel && wb_sel_i[0]) begin
         axis_next = wb_dat_i[1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         axis_reg <= AXIS_RST;
      end else begin
         axis_reg <= axis_next;
      end
   end

   // Unmapped offsets answer with zero
   always_comb begin
      rdata = 32'h0000_0000;
      if (axis_sel) begin
         rdata[1:0] = axis_reg;
      end else if (mode_sel) begin
         rdata[15:0] = mode_reg[axis_reg];
      end else if (wb_adr_i[3:2] == ADDR_STAT[3:2]) begin
         rdata[3:0]   = busy_v;
         rdata[7:4]   = dir_v;
         rdata[11:8]  = fault_v;
         rdata[13:12] = axis_reg;
      end
   end

   genvar k;
   generate
      for (k = 0; k < NUM_AXES; k++) begin : g_axis
         logic [1:0] fmt;
         logic       pol;
         logic       swap;
         logic       p1;
         logic       p2;

         assign fmt  = mode_reg[k][BIT_FMT_HI:BIT_FMT_LO];
         assign pol  = mode_reg[k][BIT_PULSE_POL];
         assign swap = mode_reg[k][BIT_SWAP];

         // Profile generator reads these directly
         assign manual_decel_select_o[k]       = mode_reg[k][BIT_MANUAL_DECEL];
         assign asymmetric_profile_select_o[k] = mode_reg[k][BIT_ASYM];
         assign scurve_select_o[k]             = mode_reg[k][BIT_SCURVE];
         // Asymmetric S-curve without manual decel cannot stop on target
         assign fault_v[k] = mode_reg[k][BIT_ASYM] & mode_reg[k][BIT_SCURVE]
                           & ~mode_reg[k][BIT_MANUAL_DECEL];
         assign busy_v[k]  = busy[k];
         assign dir_v[k]   = dir_reg[k];
         assign drive_out1_o[k] = out1_reg[k];
         assign drive_out2_o[k] = out2_reg[k];

         // Direction is captured once at move start
         assign dir_use[k] = (move_active_i[k] && !act_reg[k]) ? move_dir_i[k]
                                                                : dir_reg[k];

         ampo_axis_pulse u_pulse (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .step_i    (step_i[k] & move_active_i[k]),
            .neg_i     (dir_use[k]),
            .double_i  (fmt == FMT_QUAD2),
            .pulse_o   (pulse_raw[k]),
            .phase_a_o (phase_a[k]),
            .phase_b_o (phase_b[k]),
            .busy_o    (busy[k])
         );

         always_comb begin
            mode_next[k] = mode_reg[k];
            dir_next[k]  = dir_use[k];
            if (wr_en && mode_sel && axis_reg == 2'(k)) begin
               if (wb_sel_i[0]) begin
                  mode_next[k][7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  mode_next[k][15:8] = wb_dat_i[15:8];
               end
            end
            case (fmt)
               FMT_TWO_PULSE: begin
                  p1 = (pulse_raw[k] & ~dir_reg[k]) ^ pol;
                  p2 = (pulse_raw[k] & dir_reg[k]) ^ pol;
               end
               FMT_STEP_DIR: begin
                  p1 = pulse_raw[k] ^ pol;
                  p2 = dir_reg[k] ^ mode_reg[k][BIT_DIR_POL];
               end
               default: begin
                  p1 = phase_a[k] ^ pol;
                  p2 = phase_b[k] ^ pol;
               end
            endcase
            out1_next[k] = swap ? p2 : p1;
            out2_next[k] = swap ? p1 : p2;
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               mode_reg[k] <= MODE3_RST;
               dir_reg[k]  <= 1'b0;
               act_reg[k]  <= 1'b0;
               out1_reg[k] <= 1'b0;
               out2_reg[k] <= 1'b0;
            end else begin
               mode_reg[k] <= mode_next[k];
               dir_reg[k]  <= dir_next[k];
               act_reg[k]  <= move_active_i[k];
               out1_reg[k] <= out1_next[k];
               out2_reg[k] <= out2_next[k];
            end
         end
      end
   endgenerate

   // Checks on axis 0 except mode_write_a and asym_hold_a, which cover every axis; other axes are the same generate body
   logic [1:0] fmt0;
   assign fmt0 = mode_reg[0][BIT_FMT_HI:BIT_FMT_LO];

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   mode_write_a: assert property (
      (wr_en && mode_sel && wb_sel_i[1:0] == 2'h3)
      |=> mode_reg[$past(axis_reg)] == $past(wb_dat_i[15:0]))
      else $error("mode write missed the selected axis");

   decel_sel_a: assert property (
      (wr_en && mode_sel && axis_reg == 2'h0 && wb_sel_i[0])
      |=> manual_decel_select_o[0] == $past(wb_dat_i[BIT_MANUAL_DECEL]))
      else $error("manual decel select not taken");

   asym_hold_a: assert property (
      !(wr_en && mode_sel) |=> $stable(asymmetric_profile_select_o))
      else $error("asymmetric select changed without a write");

   curve_cause_a: assert property (
      $rose(scurve_select_o[0]) |-> $past(wr_en && mode_sel && axis_reg == 2'h0))
      else $error("scurve select rose without a write");

   two_pulse_a: assert property (
      (fmt0 == FMT_TWO_PULSE && !mode_reg[0][BIT_SWAP] && !mode_reg[0][BIT_PULSE_POL]
       && pulse_raw[0]) |=> (drive_out1_o[0] != drive_out2_o[0])
                            && drive_out2_o[0] == $past(dir_reg[0]))
      else $error("two pulse output on wrong pin");

   step_dir_a: assert property (
      (fmt0 == FMT_STEP_DIR && !mode_reg[0][BIT_SWAP])
      |=> drive_out2_o[0] == ($past(dir_reg[0]) ^ $past(mode_reg[0][BIT_DIR_POL])))
      else $error("direction level wrong");

   quad_phase_a: assert property (
      (fmt0[1] && !mode_reg[0][BIT_SWAP] && !mode_reg[0][BIT_PULSE_POL])
      |=> drive_out1_o[0] == $past(phase_a[0]) && drive_out2_o[0] == $past(phase_b[0]))
      else $error("quadrature phases not on their pins");

   pulse_pol_a: assert property (
      (fmt0 == FMT_STEP_DIR && !mode_reg[0][BIT_SWAP] && !busy[0])
      |=> drive_out1_o[0] == $past(mode_reg[0][BIT_PULSE_POL]))
      else $error("idle pulse level ignores polarity");

   pin_swap_a: assert property (
      (fmt0 == FMT_STEP_DIR && mode_reg[0][BIT_SWAP])
      |=> drive_out1_o[0] == ($past(dir_reg[0]) ^ $past(mode_reg[0][BIT_DIR_POL])))
      else $error("swap did not move direction to pin 1");

   dir_hold_a: assert property (
      (move_active_i[0] && act_reg[0]) |=> $stable(dir_reg[0]) [*2])
      else $error("direction changed during a move");

   dir_capture_a: assert property (
      (move_active_i[0] && !act_reg[0]) |=> dir_reg[0] == $past(move_dir_i[0]))
      else $error("direction not latched at move start");

   axis_write_a: assert property (
      (wr_en && axis_sel && wb_sel_i[0]) |=> axis_reg == $past(wb_dat_i[1:0]))
      else $error("axis select write not taken");

   other_axis_a: assert property (
      (wr_en && mode_sel && axis_reg != 2'h0) |=> $stable(mode_reg[0]))
      else $error("mode write leaked into axis 0");

   asym_write_a: assert property (
      (wr_en && mode_sel && axis_reg == 2'h0 && wb_sel_i[0])
      |=> asymmetric_profile_select_o[0] == $past(wb_dat_i[BIT_ASYM]))
      else $error("asymmetric select not taken");

   curve_write_a: assert property (
      (wr_en && mode_sel && axis_reg == 2'h0 && wb_sel_i[0])
      |=> scurve_select_o[0] == $past(wb_dat_i[BIT_SCURVE]))
      else $error("scurve select not taken");

   two_swap_a: assert property (
      (fmt0 == FMT_TWO_PULSE && mode_reg[0][BIT_SWAP] && !mode_reg[0][BIT_PULSE_POL]
       && pulse_raw[0]) |=> drive_out1_o[0] == $past(dir_reg[0]))
      else $error("swapped two pulse output on wrong pin");

   step_pulse_a: assert property (
      (fmt0 == FMT_STEP_DIR && !mode_reg[0][BIT_SWAP] && pulse_raw[0])
      |=> drive_out1_o[0] != $past(mode_reg[0][BIT_PULSE_POL]))
      else $error("step pulse missing on pin 1");

   quad_pol_a: assert property (
      (fmt0[1] && !mode_reg[0][BIT_SWAP] && mode_reg[0][BIT_PULSE_POL])
      |=> drive_out1_o[0] != $past(phase_a[0]) && drive_out2_o[0] != $past(phase_b[0]))
      else $error("quadrature phases ignore polarity");

   quad_swap_a: assert property (
      (fmt0[1] && mode_reg[0][BIT_SWAP])
      |=> drive_out1_o[0] == ($past(phase_b[0]) ^ $past(mode_reg[0][BIT_PULSE_POL])))
      else $error("swap did not move phase B to pin 1");

   idle_level_a: assert property (
      (fmt0 == FMT_TWO_PULSE && !busy[0])
      |=> drive_out1_o[0] == $past(mode_reg[0][BIT_PULSE_POL])
          && drive_out2_o[0] == $past(mode_reg[0][BIT_PULSE_POL]))
      else $error("two pulse pins not idle between pulses");

   // Width and gap follow the leaf counters; a faster step is dropped
   pulse_width_a: assert property (
      $rose(pulse_raw[0])
      |-> pulse_raw[0] [*2] ##1 (!pulse_raw[0]) [*2])
      else $error("drive pulse width or gap wrong");

   // Ack lasts one cycle; a master slow to drop stb is acked again every second cycle
   ack_once_a: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");
endmodule : ampo_axis_mode3

// ===== tb/ampo_drive_model.sv
// Motor driver model: counts level changes on both drive pins
`timescale 1ns/1ns
module ampo_drive_model
   import ampo_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                clr_i,
   input  wire logic [NUM_AXES-1:0] pin1_i,
   input  wire logic [NUM_AXES-1:0] pin2_i,
   output logic [3:0]               edges1_o,
   output logic [3:0]               edges2_o
);
   logic [NUM_AXES-1:0] last1_reg;
   logic [NUM_AXES-1:0] last2_reg;
   // A driver acts on every edge, so edges are counted, not levels
   always_ff @(posedge clk_i) begin
      last1_reg <= pin1_i;
      last2_reg <= pin2_i;
      if (clr_i) begin
         edges1_o <= 4'h0;
         edges2_o <= 4'h0;
      end else begin
         edges1_o <= edges1_o + 4'($countones(pin1_i ^ last1_reg));
         edges2_o <= edges2_o + 4'($countones(pin2_i ^ last2_reg));
      end
   end
endmodule : ampo_drive_model

// ===== tb/testbench.sv
// Self-checking bench for the axis mode 3 pulse output block
`timescale 1ns/1ns
module testbench;
   import ampo_pkg::*;
   logic                clk_i;
   logic                rst_i;
   logic [3:0]          adr;
   logic [31:0]         wdat;
   logic [3:0]          sel;
   logic                we;
   logic                cyc;
   logic                stb;
   logic [31:0]         rdat;
   logic                ack;
   logic [NUM_AXES-1:0] act;
   logic [NUM_AXES-1:0] dir;
   logic [NUM_AXES-1:0] step;
   logic [NUM_AXES-1:0] out1;
   logic [NUM_AXES-1:0] out2;
   logic [NUM_AXES-1:0] man;
   logic [NUM_AXES-1:0] asym;
   logic [NUM_AXES-1:0] scrv;
   logic                clr;
   logic [3:0]          edges1;
   logic [3:0]          edges2;
   logic [31:0]         q;
   logic [15:0]         m;
   logic [15:0]         mode_val [NUM_AXES];
   int                  i;
   int                  fail_count;
   int                  check_count;

   ampo_axis_mode3 u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
      .wb_ack_o(ack), .move_active_i(act), .move_dir_i(dir), .step_i(step),
      .drive_out1_o(out1), .drive_out2_o(out2), .manual_decel_select_o(man),
      .asymmetric_profile_select_o(asym), .scurve_select_o(scrv));
   ampo_drive_model u_drv (.clk_i(clk_i), .clr_i(clr), .pin1_i(out1), .pin2_i(out2),
      .edges1_o(edges1), .edges2_o(edges2));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      // No local limit: a hung access is ended by the watchdog
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb

   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   // ph: 0 before the step, 1 pulse active, 2 after the pulse
   function automatic logic [1:0] exp_pins(logic [7:0] md, logic d, int ph);
      logic       p;
      logic [1:0] r;
      p = md[5];
      case (md[4:3])
         2'h0: r = {((ph == 1) && d) ^ p, ((ph == 1) && !d) ^ p};
         2'h1: r = {d ^ md[6], (ph == 1) ^ p};
         2'h2: r = (ph == 0) ? {p, p} : {d ^ p, !d ^ p};
         default: r = (ph == 0) ? {p, p} : (ph == 1) ? {d ^ p, !d ^ p} : {!p, !p};
      endcase
      return md[7] ? {r[0], r[1]} : r;
   endfunction : exp_pins

   function automatic logic [7:0] exp_tog(logic [7:0] md, logic d);
      logic [7:0] t;
      case (md[4:3])
         2'h0: t = d ? 8'h20 : 8'h02;
         2'h1: t = 8'h02;
         2'h2: t = d ? 8'h10 : 8'h01;
         default: t = 8'h11;
      endcase
      return md[7] ? {t[3:0], t[7:4]} : t;
   endfunction : exp_tog

   task automatic pins(input int ax, input logic [15:0] md, input logic d, input int ph);
      logic [1:0]          r;
      logic [NUM_AXES-1:0] e1;
      logic [NUM_AXES-1:0] e2;
      r = exp_pins(md[7:0], d, ph);
      e1 = 4'h0;
      e2 = 4'h0;
      e1[ax] = r[0];
      e2[ax] = r[1];
      check({28'h0, out1}, {28'h0, e1});
      check({28'h0, out2}, {28'h0, e2});
   endtask : pins

   task automatic run_move(input int ax, input logic [15:0] md, input logic d);
      wb(ADDR_AXIS, 1'b1, 32'(ax), 4'h1, q);
      wb(ADDR_MODE3, 1'b1, {16'h0000, md}, 4'h3, q);
      // Mode register takes the write at the ack edge; look one edge later
      @(posedge clk_i);
      check({29'h0, scrv[ax], asym[ax], man[ax]}, {29'h0, md[2:0]});
      act[ax] <= 1'b1;
      dir[ax] <= d;
      repeat (3) @(posedge clk_i);
      step[ax] <= 1'b1;
      clr <= 1'b1;
      @(posedge clk_i);
      step[ax] <= 1'b0;
      clr <= 1'b0;
      // Direction input flips mid-move; output must not follow
      dir[ax] <= ~d;
      pins(ax, md, d, 0);
      @(posedge clk_i);
      // Too soon: must be dropped while the axis is busy
      step[ax] <= 1'b1;
      @(posedge clk_i);
      step[ax] <= 1'b0;
      @(posedge clk_i);
      pins(ax, md, d, 1);
      repeat (3) @(posedge clk_i);
      pins(ax, md, d, 2);
      check({24'h0, edges2, edges1}, {24'h0, exp_tog(md[7:0], d)});
      // Status keeps the latched direction although the input flipped
      wb(ADDR_STAT, 1'b0, 32'h0000_0000, 4'hf, q);
      check(q, {18'h0, 2'(ax), 4'h0, 4'(d) << ax, 4'h0});
      act[ax] <= 1'b0;
   endtask : run_move

   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      end_of_test();
   end

   initial begin
      fail_count = 0;
      check_count = 0;
      rst_i = 1'b1;
      {cyc, stb, we, clr} = 4'h0;
      adr = 4'h0;
      wdat = 32'h0000_0000;
      sel = 4'h0;
      act = 4'h0;
      dir = 4'h0;
      step = 4'h0;
      void'($urandom(32'hc98e));
      do_reset();
      wb(ADDR_MODE3, 1'b0, 32'h0000_0000, 4'hf, q);
      check(q, {16'h0000, MODE3_RST});
      for (i = 0; i < NUM_AXES; i++) begin
         mode_val[i] = 16'($urandom) & 16'h7fff;
         wb(ADDR_AXIS, 1'b1, 32'(i), 4'h1, q);
         wb(ADDR_MODE3, 1'b1, {16'h0000, mode_val[i]}, 4'h3, q);
      end
      wb(ADDR_AXIS, 1'b1, 32'h0000_0002, 4'h1, q);
      // Lane 0 only: upper byte must survive
      wb(ADDR_MODE3, 1'b1, 32'h0000_5aa5, 4'h1, q);
      mode_val[2][7:0] = 8'ha5;
      for (i = 0; i < NUM_AXES; i++) begin
         wb(ADDR_AXIS, 1'b1, 32'(i), 4'h1, q);
         wb(ADDR_MODE3, 1'b0, 32'h0000_0000, 4'h3, q);
         check(q, {16'h0000, mode_val[i]});
         check({29'h0, scrv[i], asym[i], man[i]}, {29'h0, mode_val[i][2:0]});
      end
      // Fault bits flag asymmetric S-curve setups that lack manual decel
      m = 16'h3000;
      for (i = 0; i < NUM_AXES; i++) begin
         m[8 + i] = mode_val[i][1] & mode_val[i][2] & ~mode_val[i][0];
      end
      wb(ADDR_STAT, 1'b0, 32'h0000_0000, 4'hf, q);
      check(q, {16'h0000, m});
      wb(4'hc, 1'b1, 32'hffff_ffff, 4'hf, q);
      wb(4'hc, 1'b0, 32'h0000_0000, 4'hf, q);
      check(q, 32'h0000_0000);
      for (i = 0; i < 32; i++) begin
         m = (i < 8) ? 16'h0000 : 16'($urandom) & 16'h00e7;
         m[4:3] = i[1:0];
         // Asymmetric S-curve needs manual deceleration
         if (m[1] && m[2]) m[0] = 1'b1;
         do_reset();
         run_move(int'($urandom % NUM_AXES), m, (i < 8) ? i[2] : 1'($urandom));
      end
      end_of_test();
   end
endmodule : testbench
